// ---- hw/cled_blink.sv ----
// Square-wave generator for one blink rate with equal on and off phases.
// Assumes the clock and reset of the indicator controller.
`timescale 1ns/1ps
module cled_blink #(
  parameter int unsigned HALF = 2
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Blink phase
  output logic      o_phase
);
  import cled_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             ph;
  } cled_blk_t;

  cled_blk_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.cnt >= CNT_W'(HALF - 1)) begin
      s_d.cnt = '0;
      s_d.ph  = ~s_q.ph;
    end else begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{cnt: '0, ph: BLINK_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_phase = s_q.ph;

  // Both phases last exactly HALF cycles.
  property p_half;
    @(posedge i_clk) disable iff (i_rst)
      $changed(s_q.ph) |-> s_q.cnt == '0;
  endproperty
  a_half: assert property (p_half) else $error("blink phase length wrong");

endmodule : cled_blink

// ---- hw/cled_pkg.sv ----
// Constants for the adapter indicator light controller.
// Assumes a single 25 MHz system clock shared by every file of the block.
package cled_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned SLOW_HALF_MS  = 500;
  localparam int unsigned FAST_HALF_MS  = 100;
  localparam int unsigned LOAD_WIN_MS   = 100;
  localparam int unsigned ANIM_STEP_MS  = 50;
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / 1000 * SLOW_HALF_MS;
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / 1000 * FAST_HALF_MS;
  localparam int unsigned LOAD_WIN_CYC  = CLK_HZ / 1000 * LOAD_WIN_MS;
  localparam int unsigned ANIM_STEP_CYC = CLK_HZ / 1000 * ANIM_STEP_MS;

  // ---------------------------------------------------------------------
  // Geometry and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned BAR_SEGS  = 8;
  localparam int unsigned CNT_W     = 32;
  localparam logic        BLINK_RST = 1'b0;

  // ---------------------------------------------------------------------
  // Colours, one bit each for red, green and blue.
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    CLED_OFF    = 3'h0,
    CLED_BLUE   = 3'h1,
    CLED_GREEN  = 3'h2,
    CLED_RED    = 3'h4,
    CLED_YELLOW = 3'h6,
    CLED_WHITE  = 3'h7
  } cled_col_t;

endpackage : cled_pkg

// ---- hw/cled_top.sv ----
// Indicator light controller for a single-channel host-to-CAN adapter.
// Assumes status inputs and bit-tick pulses are synchronous to i_clk.
`timescale 1ns/1ps
module cled_top
  import cled_pkg::*;
#(
  parameter int unsigned SLOW_HALF = cled_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = cled_pkg::FAST_HALF_CYC,
  parameter int unsigned LOAD_WIN  = cled_pkg::LOAD_WIN_CYC,
  parameter int unsigned ANIM_STEP = cled_pkg::ANIM_STEP_CYC,
  parameter int unsigned SEGS      = cled_pkg::BAR_SEGS
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // Adapter state
  input  wire logic                  i_power_on,
  input  wire logic                  i_cfg_wait,
  input  wire logic                  i_bus_on,
  input  wire logic                  i_err_passive,
  // Bus activity: busy levels, sampled on a one-cycle pulse per bus bit time
  input  wire logic                  i_tx_busy,
  input  wire logic                  i_rx_busy,
  input  wire logic                  i_bit_tick,
  // Transmit bar: segment 0 is the host end, holds the status area
  output logic [2:0]                 o_tx_stat_rgb,
  output logic [SEGS-1:0]            o_tx_bar_on,
  output logic [2:0]                 o_tx_bar_rgb,
  // Receive bar: segment 0 is the CAN end, holds the status area
  output logic [2:0]                 o_rx_stat_rgb,
  output logic [SEGS-1:0]            o_rx_bar_on,
  output logic [2:0]                 o_rx_bar_rgb
);
  import cled_pkg::*;

  localparam int unsigned LW = $clog2(SEGS + 1);

  typedef struct packed {
    logic [CNT_W-1:0] win;
    logic [CNT_W-1:0] bits;
    logic [CNT_W-1:0] txb;
    logic [CNT_W-1:0] rxb;
    logic [LW-1:0]    tx_len;
    logic [LW-1:0]    rx_len;
    logic             tx_act;
    logic             rx_act;
    logic [CNT_W-1:0] anim;
    logic [LW-1:0]    ph;
    logic [2:0]       tx_stat;
    logic [2:0]       rx_stat;
    logic [SEGS-1:0]  tx_bar;
    logic [SEGS-1:0]  rx_bar;
  } cled_st_t;

  cled_st_t s_q, s_d;
  logic     slow_ph;
  logic     fast_ph;

  // -----------------------------------------------------------------------
  // Blink sources
  // -----------------------------------------------------------------------
  // The slow rate is kept for the locate and update modes, which are driven
  // elsewhere; it still runs so its timing can be checked.
  cled_blink #(.HALF(SLOW_HALF)) u_slow (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .o_phase (slow_ph)
  );
  cled_blink #(.HALF(FAST_HALF)) u_fast (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .o_phase (fast_ph)
  );

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  // Scales a bit count to lit segments against the whole window's bits, so
  // both bars share one scale and their sum tracks total load.
  function automatic logic [LW-1:0] seg_len(input logic [CNT_W-1:0] part,
                                            input logic [CNT_W-1:0] tot);
    logic [CNT_W+7:0] q;
    q = '0;
    if (tot != '0) begin
      q = ({8'h00, part} * (CNT_W+8)'(SEGS)) / {8'h00, tot};
    end
    if (q > (CNT_W+8)'(SEGS)) begin
      q = (CNT_W+8)'(SEGS);
    end
    return q[LW-1:0];
  endfunction : seg_len

  // Thermometer fill of len segments; a travelling dark dot animates fills of two or more.
  function automatic logic [SEGS-1:0] fill(input logic [LW-1:0] len,
                                           input logic [LW-1:0] ph);
    logic [SEGS-1:0] m;
    m = '0;
    for (int i = 0; i < SEGS; i++) begin
      if (LW'(i) < len && !(len > LW'(1) && LW'(i) == ph)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : fill

  // Status priority shared by both status areas.
  function automatic logic [2:0] stat_col(input logic traf, input logic fph);
    logic [2:0] c;
    c = CLED_OFF;
    if (i_cfg_wait) begin
      c = fph ? CLED_BLUE : CLED_OFF;
    end else if (i_err_passive) begin
      c = fph ? CLED_RED : CLED_OFF;
    end else if (traf) begin
      c = CLED_YELLOW;
    end else if (i_bus_on) begin
      c = CLED_GREEN;
    end else if (i_power_on) begin
      c = CLED_WHITE;
    end
    return c;
  endfunction : stat_col

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Load window: the load is measured, not the instantaneous activity,
    // so the bars settle instead of flickering at frame rate.
    if (i_bit_tick) begin
      s_d.bits = s_q.bits + CNT_W'(1);
      if (i_tx_busy) begin
        s_d.txb = s_q.txb + CNT_W'(1);
      end
      if (i_rx_busy) begin
        s_d.rxb = s_q.rxb + CNT_W'(1);
      end
    end
    if (s_q.win >= CNT_W'(LOAD_WIN - 1)) begin
      s_d.win    = '0;
      s_d.bits   = '0;
      s_d.txb    = '0;
      s_d.rxb    = '0;
      s_d.tx_len = seg_len(s_q.txb, s_q.bits);
      s_d.rx_len = seg_len(s_q.rxb, s_q.bits);
      s_d.tx_act = s_q.txb != '0;
      s_d.rx_act = s_q.rxb != '0;
    end else begin
      s_d.win = s_q.win + CNT_W'(1);
    end
    if (s_q.anim >= CNT_W'(ANIM_STEP - 1)) begin
      s_d.anim = '0;
      s_d.ph   = (s_q.ph >= LW'(SEGS - 1)) ? '0 : s_q.ph + LW'(1);
    end else begin
      s_d.anim = s_q.anim + CNT_W'(1);
    end
    s_d.tx_stat = stat_col(s_q.tx_act, fast_ph);
    s_d.rx_stat = stat_col(s_q.rx_act, fast_ph);
    s_d.tx_bar  = fill(s_q.tx_len, s_q.ph);
    s_d.rx_bar  = fill(s_q.rx_len, s_q.ph);
    if (!i_power_on) begin
      s_d.tx_stat = CLED_OFF;
      s_d.rx_stat = CLED_OFF;
      s_d.tx_bar  = '0;
      s_d.rx_bar  = '0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  // Status areas sit at segment 0 of each bar: host end for transmit, CAN
  // end for receive, so the two bars fill toward each other.
  assign o_tx_stat_rgb = s_q.tx_stat;
  assign o_rx_stat_rgb = s_q.rx_stat;
  assign o_tx_bar_on   = s_q.tx_bar;
  assign o_rx_bar_on   = s_q.rx_bar;
  assign o_tx_bar_rgb  = CLED_YELLOW;
  assign o_rx_bar_rgb  = CLED_YELLOW;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  sequence s_cfg;
    i_cfg_wait && i_power_on;
  endsequence

  property p_cfg;
    @(posedge i_clk) disable iff (i_rst)
      s_cfg ##1 1 |-> (o_tx_stat_rgb == CLED_BLUE
                       || o_tx_stat_rgb == CLED_OFF);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config wait not blue");

  property p_errp;
    @(posedge i_clk) disable iff (i_rst)
      (!i_cfg_wait && i_err_passive && i_power_on) |=>
        (o_rx_stat_rgb == CLED_RED || o_rx_stat_rgb == CLED_OFF);
  endproperty
  a_errp: assert property (p_errp) else $error("error passive not red");

  property p_white;
    @(posedge i_clk) disable iff (i_rst)
      (i_power_on && !i_cfg_wait && !i_err_passive && !i_bus_on
       && !s_q.tx_act) |=> o_tx_stat_rgb == CLED_WHITE;
  endproperty
  a_white: assert property (p_white) else $error("idle not white");

  property p_green;
    @(posedge i_clk) disable iff (i_rst)
      (i_power_on && !i_cfg_wait && !i_err_passive && i_bus_on
       && !s_q.rx_act) |=> o_rx_stat_rgb == CLED_GREEN;
  endproperty
  a_green: assert property (p_green) else $error("bus on not green");

  property p_yel;
    @(posedge i_clk) disable iff (i_rst)
      (i_power_on && !i_cfg_wait && !i_err_passive && s_q.tx_act)
        |=> o_tx_stat_rgb == CLED_YELLOW;
  endproperty
  a_yel: assert property (p_yel) else $error("traffic not yellow");

  property p_off;
    @(posedge i_clk) disable iff (i_rst)
      !i_power_on |=> (o_tx_stat_rgb == CLED_OFF && o_rx_bar_on == '0);
  endproperty
  a_off: assert property (p_off) else $error("unpowered light lit");

  property p_sum;
    @(posedge i_clk) disable iff (i_rst)
      1 |-> (s_q.tx_len + s_q.rx_len) <= (LW+1)'(SEGS);
  endproperty
  a_sum: assert property (p_sum) else $error("bar sum exceeds bar");

  property p_len;
    @(posedge i_clk) disable iff (i_rst)
      $changed(s_q.tx_len) |-> $past(s_q.win) >= CNT_W'(LOAD_WIN - 1);
  endproperty
  a_len: assert property (p_len) else $error("length off window");

  property p_fill;
    @(posedge i_clk) disable iff (i_rst)
      (i_power_on && s_q.rx_len == '0) |=> o_rx_bar_on == '0;
  endproperty
  a_fill: assert property (p_fill) else $error("rx bar lit at no load");

endmodule : cled_top

// ---- tb/cled_bar_model.sv ----
// Observer model of one indicator bar: records what a viewer would see.
// Assumes bit 0 of the segment mask is the end that holds the status area.
`timescale 1ns/1ps
module cled_bar_model #(
  parameter int unsigned SEGS = 8
) (
  // Clock and observation control
  input  wire logic            i_clk,
  input  wire logic            i_clr,
  // Bar drive from the controller
  input  wire logic [SEGS-1:0] i_bar_on,
  // Union of lit segments and count of pattern changes since the clear
  output logic [SEGS-1:0]      o_seen,
  output logic [7:0]           o_moves
);
  logic [SEGS-1:0] prev_q;

  // The dark dot hides one segment at a time, so the lit length is read
  // as the union of masks seen over a few animation steps.
  always @(posedge i_clk) begin
    prev_q <= i_bar_on;
    if (i_clr) begin
      o_seen  <= '0;
      o_moves <= 8'h00;
    end else begin
      o_seen <= o_seen | i_bar_on;
      if (i_bar_on != prev_q && o_moves != 8'hff) begin
        o_moves <= o_moves + 8'h01;
      end
    end
  end
endmodule : cled_bar_model

// ---- tb/cled_top_tb_top.sv ----
// Self-checking bench for the indicator light controller.
// Assumes short timing parameters so that blink and load windows are fast.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  mismatches++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module cled_top_tb_top;
  import cled_pkg::*;
  localparam int unsigned SG = 8;
  logic          i_clk = 1'b0, i_rst = 1'b1, clr = 1'b1;
  logic          pw = 1'b0, cw = 1'b0, bo = 1'b0, ep = 1'b0;
  logic          txb = 1'b0, rxb = 1'b0, tick = 1'b0, sel = 1'b0;
  logic [1:0]    md = 2'h0;
  logic [2:0]    tsr, rsr, tbr, rbr;
  logic [SG-1:0] tbo, rbo, tseen, rseen;
  logic [7:0]    tmv, rmv;
  int            mismatches = 0, cmp_count = 0;

  always #20 i_clk = ~i_clk;

  // ---------------------------------------------------------------------
  // Bus activity: a bit tick every other cycle; mode 1 transmits on all
  // bits, mode 2 alternates transmit and receive bits.
  // ---------------------------------------------------------------------
  always @(posedge i_clk) begin
    tick <= (md != 2'h0) & ~tick;
    if (tick) sel <= ~sel;
    txb <= md[0] | (md[1] & sel);
    rxb <= md[1] & ~sel;
  end

  cled_top #(.SLOW_HALF(4), .FAST_HALF(2), .LOAD_WIN(20), .ANIM_STEP(3),
    .SEGS(SG)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_power_on(pw),
    .i_cfg_wait(cw), .i_bus_on(bo), .i_err_passive(ep), .i_tx_busy(txb),
    .i_rx_busy(rxb), .i_bit_tick(tick), .o_tx_stat_rgb(tsr),
    .o_tx_bar_on(tbo), .o_tx_bar_rgb(tbr), .o_rx_stat_rgb(rsr),
    .o_rx_bar_on(rbo), .o_rx_bar_rgb(rbr));
  cled_bar_model #(.SEGS(SG)) tx_bar (.i_clk(i_clk), .i_clr(clr),
    .i_bar_on(tbo), .o_seen(tseen), .o_moves(tmv));
  cled_bar_model #(.SEGS(SG)) rx_bar (.i_clk(i_clk), .i_clr(clr),
    .i_bar_on(rbo), .o_seen(rseen), .o_moves(rmv));

  typedef struct packed {
    logic [3:0] in; logic [2:0] col; logic [3:0] on;
  } cled_row_t;
  // Inputs {power, cfg wait, bus on, error passive}, colour, lit cycles of 8.
  cled_row_t rows [6] = '{
    '{4'h8, 3'h7, 4'h8},
    '{4'hc, 3'h1, 4'h4},
    '{4'ha, 3'h2, 4'h8},
    '{4'hb, 3'h4, 4'h4},
    '{4'hf, 3'h1, 4'h4},
    '{4'h2, 3'h0, 4'h8}};

  task automatic summarize;
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    summarize();
  end

  initial begin
    int on_t, on_r, bad;
    cyc(20);
    `CHK("tx_stat_rst", 3'h0, tsr)
    `CHK("tx_bar_rst", 8'h00, tbo)
    `CHK("bar_rgb", 3'h6, tbr)
    @(posedge i_clk) i_rst <= 1'b0;
    // Steady colours must hold every cycle; fast blink is lit half the time.
    foreach (rows[k]) begin
      @(posedge i_clk) {pw, cw, bo, ep} <= rows[k].in;
      cyc(4);
      on_t = 0; on_r = 0; bad = 0;
      for (int c = 0; c < 8; c++) begin
        on_t += (tsr === rows[k].col);
        on_r += (rsr === rows[k].col);
        bad += (tsr !== rows[k].col && tsr !== 3'h0);
        cyc(1);
      end
      `CHK("tx_on", rows[k].on, 4'(on_t))
      `CHK("rx_on", rows[k].on, 4'(on_r))
      `CHK("stray", 0, bad)
    end
    // Full transmit load: whole transmit bar from the host end.
    @(posedge i_clk) begin {pw, cw, bo, ep} <= 4'ha; md <= 2'h1; end
    cyc(50);
    clr <= 1'b0;
    cyc(14);
    `CHK("tx_stat_traf", 3'h6, tsr)
    `CHK("rx_stat_traf", 3'h2, rsr)
    `CHK("tx_len_full", 8'hff, tseen)
    `CHK("rx_len_none", 8'h00, rseen)
    `CHK("tx_dynamic", 1'b1, tmv != 8'h00)
    // Half and half: each bar half lit, same combined length.
    @(posedge i_clk) begin md <= 2'h2; clr <= 1'b1; end
    cyc(50);
    clr <= 1'b0;
    cyc(14);
    `CHK("tx_len_half", 8'h0f, tseen)
    `CHK("rx_len_half", 8'h0f, rseen)
    `CHK("sum_len", 8'hff, {rseen[3:0], tseen[3:0]})
    `CHK("rx_dynamic", 1'b1, rmv != 8'h00)
    // Error passive outranks traffic.
    @(posedge i_clk) ep <= 1'b1;
    cyc(4);
    bad = 0;
    for (int c = 0; c < 8; c++) begin
      bad += (tsr === 3'h4);
      cyc(1);
    end
    `CHK("errp_over_traf", 4, bad)
    // Power loss and a reset in mid-run both darken the status areas.
    @(posedge i_clk) pw <= 1'b0;
    cyc(3);
    `CHK("pwr_off", 3'h0, tsr)
    @(posedge i_clk) begin pw <= 1'b1; i_rst <= 1'b1; end
    cyc(2);
    `CHK("rst_mid", 3'h0, rsr)
    summarize();
  end
endmodule : cled_top_tb_top
